/* bench/cotr_offset_trim_checker.sv */
`timescale 1ns/1ps
module cotr_offset_trim_checker (
   input wire logic        core_clk, rst_n, regWrStb, regRdStb, fuseLoad, fgCalEn,
   input wire logic        coreASecondInput, coreAPhase90, coreBSecondInput, coreBPhase90,
   input wire logic        coreATrimValid, coreBTrimValid,
   input wire logic [11:0] regAddr, coreATrim, coreBTrim,
   input wire logic [15:0] regWrData, regRdData, fuseCoreASecondPh0
);
   logic [2:0] upCnt;
   // outputs lag the two-flop reset release, so wait before judging
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) upCnt <= 3'h0;
      else if (upCnt != 3'h4) upCnt <= upCnt + 3'h1;
   end
   wire live = (upCnt == 3'h4);
   wire mapped = (regAddr == 12'h346) || (regAddr == 12'h348) || (regAddr == 12'h34A) || (regAddr == 12'h34C);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   property p_a_in2_ph0; live && fgCalEn && coreASecondInput && !coreAPhase90 |=> coreATrimValid; endproperty
   a_a_in2_ph0: assert property (p_a_in2_ph0) else $error("core A trim not valid");
   property p_a_in1_ph90; live && fgCalEn && !coreASecondInput && coreAPhase90 |=> coreATrimValid; endproperty
   a_a_in1_ph90: assert property (p_a_in1_ph90) else $error("core A trim not valid");
   property p_a_in2_ph90; live && fgCalEn && coreASecondInput && coreAPhase90 |=> coreATrimValid; endproperty
   a_a_in2_ph90: assert property (p_a_in2_ph90) else $error("core A trim not valid");
   property p_b_in1_ph0; live && fgCalEn && !coreBSecondInput && !coreBPhase90 |=> coreBTrimValid; endproperty
   a_b_in1_ph0: assert property (p_b_in1_ph0) else $error("core B trim not valid");
   property p_b_other; live && !(fgCalEn && !coreBSecondInput && !coreBPhase90) |=> !coreBTrimValid && coreBTrim == 12'h000; endproperty
   a_b_other: assert property (p_b_other) else $error("core B trim applied wrongly");
   property p_cal_off; live && !fgCalEn |=> !coreATrimValid && coreATrim == 12'h000; endproperty
   a_cal_off: assert property (p_cal_off) else $error("core A trim with calibration off");
   property p_wr_rd; live && regWrStb && mapped && !fuseLoad ##1 regRdStb && !fuseLoad && regAddr == $past(regAddr) |=> regRdData == $past(regWrData, 2); endproperty
   a_wr_rd: assert property (p_wr_rd) else $error("read back differs from write");
   property p_fuse; live && fuseLoad ##1 regRdStb && !fuseLoad && regAddr == 12'h346 |=> regRdData == $past(fuseCoreASecondPh0, 2); endproperty
   a_fuse: assert property (p_fuse) else $error("fuse word not loaded");
   property p_unmapped; live && regRdStb && !mapped |=> regRdData == 16'h0000; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
bind cotr_offset_trim cotr_offset_trim_checker u_chk (.*);

/* bench/tb.sv */
`timescale 1ns/1ps
module tb;
   logic        core_clk = 1'b0, rst_n = 1'b0, regWrStb = 1'b0, regRdStb = 1'b0, fuseLoad = 1'b0, fgCalEn = 1'b0;
   logic        coreASecondInput = 1'b0, coreAPhase90 = 1'b0, coreBSecondInput = 1'b0, coreBPhase90 = 1'b0;
   logic [11:0] regAddr = 12'h000;
   logic [15:0] regWrData = 16'h0000, fuseCoreASecondPh0 = 16'h0000, fuseCoreAFirstPh90 = 16'h0000;
   logic [15:0] fuseCoreASecondPh90 = 16'h0000, fuseCoreBFirstPh0 = 16'h0000, regRdData;
   logic [11:0] coreATrim, coreBTrim;
   logic        coreATrimValid, coreBTrimValid;
   logic [15:0] mem [4];
   int          n_errors = 0, num_checks = 0, cyc = 0;
   cotr_offset_trim u_dut (.*);
   initial forever #12.5 core_clk = ~core_clk;
   // hang guard, the whole run needs under a hundred cycles
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         stop_test();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      regWrStb <= 1'b1; regAddr <= a; regWrData <= d;
      @(posedge core_clk);
      regWrStb <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [15:0] exp);
      regRdStb <= 1'b1; regAddr <= a;
      @(posedge core_clk);
      regRdStb <= 1'b0;
      #1 chk(regRdData, exp);
   endtask
   // fuse words land in all four slots; a same-cycle write loses
   task automatic t_fuse();
      @(posedge core_clk);
      fuseCoreASecondPh0 <= 16'hA346; fuseCoreAFirstPh90 <= 16'hB348;
      fuseCoreASecondPh90 <= 16'hC34A; fuseCoreBFirstPh0 <= 16'hD34C;
      fuseLoad <= 1'b1; regWrStb <= 1'b1; regAddr <= 12'h34C; regWrData <= 16'h0BAD;
      @(posedge core_clk);
      fuseLoad <= 1'b0; regWrStb <= 1'b0;
      mem = '{16'hA346, 16'hB348, 16'hC34A, 16'hD34C};
      for (int i = 0; i < 4; i++) rd(12'h346 + 12'(2 * i), mem[i]);
   endtask
   // each register reads back its written word, reserved nibble included; holes read zero
   task automatic t_regs();
      for (int i = 0; i < 4; i++) begin
         mem[i] = 16'hF5A0 - 16'(16'h3013 * i);
         wr(12'h346 + 12'(2 * i), mem[i]);
         rd(12'h346 + 12'(2 * i), mem[i]);
      end
      wr(12'h347, 16'hFFFF);
      rd(12'h347, 16'h0000);
      rd(12'h34E, 16'h0000);
      rd(12'h348, mem[1]);
   endtask
   // software update keeps the reserved nibble by read-modify-write
   task automatic t_rmw();
      logic [15:0] cur;
      regRdStb <= 1'b1; regAddr <= 12'h34A;
      @(posedge core_clk);
      regRdStb <= 1'b0;
      #1 cur = regRdData;
      chk(cur, mem[2]);
      wr(12'h34A, {cur[15:12], 12'h123});
      mem[2] = {mem[2][15:12], 12'h123};
      rd(12'h34A, mem[2]);
   endtask
   // walk all mode combinations and compare the applied trims
   task automatic t_sel();
      logic [15:0] expA, expB;
      for (int k = 0; k < 8; k++) begin
         @(posedge core_clk);
         fgCalEn <= k[2]; coreASecondInput <= k[1]; coreAPhase90 <= k[0];
         coreBSecondInput <= k[1]; coreBPhase90 <= k[0];
         expA = 16'h0000;
         if (k[2] && (k[1] || k[0])) expA = {4'h1, mem[k[0] ? (k[1] ? 2 : 1) : 0][11:0]};
         expB = (k[2] && !k[1] && !k[0]) ? {4'h1, mem[3][11:0]} : 16'h0000;
         @(posedge core_clk);
         @(posedge core_clk);
         #1 chk({3'h0, coreATrimValid, coreATrim}, expA);
         chk({3'h0, coreBTrimValid, coreBTrim}, expB);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      t_fuse();
      t_sel();
      t_regs();
      t_rmw();
      t_sel();
      stop_test();
   end
endmodule

/* hdl/cotr_offset_trim.sv */
// Added by the designer: the strobed register port.
`timescale 1ns/1ps

// Function
// - core A, second input, 0 degree phase, calibration on: use register 0x346.
// - core A, first input, 90 degree phase, calibration on: use register 0x348.
// - core A, second input, 90 degree phase, calibration on: use register 0x34A.
// - core B, first input, 0 degree phase, calibration on: use register 0x34C.
// - registers load factory fuse values; software may read and overwrite them.
// - bits 11..0 hold the offset; bits 15..12 reserved, readable and writable.
module cotr_offset_trim (
   // clock and reset
   input  wire logic                             core_clk,
   input  wire logic                             rst_n,
   // register port
   input  wire logic [cotr_pkg::ADDR_W-1:0]      regAddr,
   input  wire logic [cotr_pkg::DATA_W-1:0]      regWrData,
   input  wire logic                             regWrStb,
   input  wire logic                             regRdStb,
   output logic      [cotr_pkg::DATA_W-1:0]      regRdData,
   // fuse storage, one load pulse with all four words
   input  wire logic                             fuseLoad,
   input  wire logic [cotr_pkg::DATA_W-1:0]      fuseCoreASecondPh0,
   input  wire logic [cotr_pkg::DATA_W-1:0]      fuseCoreAFirstPh90,
   input  wire logic [cotr_pkg::DATA_W-1:0]      fuseCoreASecondPh90,
   input  wire logic [cotr_pkg::DATA_W-1:0]      fuseCoreBFirstPh0,
   // converter operating state
   input  wire logic                             fgCalEn,
   input  wire logic                             coreASecondInput,
   input  wire logic                             coreAPhase90,
   input  wire logic                             coreBSecondInput,
   input  wire logic                             coreBPhase90,
   // offset correction towards the cores
   output logic      [cotr_pkg::TRIM_W-1:0]      coreATrim,
   output logic                                  coreATrimValid,
   output logic      [cotr_pkg::TRIM_W-1:0]      coreBTrim,
   output logic                                  coreBTrimValid
);

   // maps a bus address onto a bank slot; hit is the top bit
   function automatic logic [2:0] decodeAddr(input logic [cotr_pkg::ADDR_W-1:0] addr);
      logic [2:0] res;
      res = 3'h0;
      case (addr)
         cotr_pkg::OFS_CORE_A_SECOND_INPUT_PHASE0_OFFSET:  res = {1'b1, cotr_pkg::IDX_A_IN2_PH0};
         cotr_pkg::OFS_CORE_A_FIRST_INPUT_PHASE90_OFFSET:  res = {1'b1, cotr_pkg::IDX_A_IN1_PH90};
         cotr_pkg::OFS_CORE_A_SECOND_INPUT_PHASE90_OFFSET: res = {1'b1, cotr_pkg::IDX_A_IN2_PH90};
         cotr_pkg::OFS_CORE_B_FIRST_INPUT_PHASE0_OFFSET:   res = {1'b1, cotr_pkg::IDX_B_IN1_PH0};
         default:                                          res = 3'h0;
      endcase
      return res;
   endfunction

   // a slot takes a software write only when addressed and no fuse load is due
   function automatic logic slotWrite(input logic       hit,
                                      input logic       load,
                                      input logic [1:0] idx,
                                      input logic [1:0] slot);
      logic res;
      res = hit & ~load & (idx == slot);
      return res;
   endfunction

   // next word of one slot: fuse load first, then software, else hold
   function automatic logic [cotr_pkg::DATA_W-1:0] nextWord(input logic                        load,
                                                            input logic                        we,
                                                            input logic [cotr_pkg::DATA_W-1:0] fuse,
                                                            input logic [cotr_pkg::DATA_W-1:0] wdata,
                                                            input logic [cotr_pkg::DATA_W-1:0] cur);
      logic [cotr_pkg::DATA_W-1:0] res;
      if (load) begin
         res = fuse;
      end else if (we) begin
         res = wdata;
      end else begin
         res = cur;
      end
      return res;
   endfunction

   // offset field of a stored word; the reserved nibble never reaches a core
   function automatic logic [cotr_pkg::TRIM_W-1:0] trimField(input logic [cotr_pkg::DATA_W-1:0] word);
      logic [cotr_pkg::TRIM_W-1:0] res;
      res = word[cotr_pkg::TRIM_MSB:cotr_pkg::TRIM_LSB];
      return res;
   endfunction

   // true when calibration runs and the core sits in the wanted input and phase
   function automatic logic modeHit(input logic calEn,
                                    input logic second,
                                    input logic phase90,
                                    input logic wantSecond,
                                    input logic wantPhase90);
      logic res;
      res = calEn & (second == wantSecond) & (phase90 == wantPhase90);
      return res;
   endfunction

   // reset release through two flops, assert stays asynchronous
   logic        rstSync1_q;
   logic        rstSync2_q;
   logic        rstInt_n;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstSync1_q <= 1'b0;
         rstSync2_q <= 1'b0;
      end else begin
         rstSync1_q <= 1'b1;
         rstSync2_q <= rstSync1_q;
      end
   end
   assign rstInt_n = rstSync2_q;

   // address decode, shared by read and write
   logic [2:0]  decoded;
   logic        addrHit;
   logic [1:0]  addrIdx;
   logic        wrHit;
   logic        rdHit;

   assign decoded = decodeAddr(regAddr);
   assign addrHit = decoded[2];
   assign addrIdx = decoded[1:0];
   assign wrHit   = regWrStb & addrHit;
   assign rdHit   = regRdStb & addrHit;

   // per-slot software write enables
   logic        wrEnAIn2Ph0;
   logic        wrEnAIn1Ph90;
   logic        wrEnAIn2Ph90;
   logic        wrEnBIn1Ph0;

   // fuse load masks a same-cycle write
   assign wrEnAIn2Ph0  = slotWrite(wrHit, fuseLoad, addrIdx, cotr_pkg::IDX_A_IN2_PH0);
   assign wrEnAIn1Ph90 = slotWrite(wrHit, fuseLoad, addrIdx, cotr_pkg::IDX_A_IN1_PH90);
   assign wrEnAIn2Ph90 = slotWrite(wrHit, fuseLoad, addrIdx, cotr_pkg::IDX_A_IN2_PH90);
   assign wrEnBIn1Ph0  = slotWrite(wrHit, fuseLoad, addrIdx, cotr_pkg::IDX_B_IN1_PH0);

   // trim storage, all sixteen bits kept
   logic [cotr_pkg::DATA_W-1:0] slotAIn2Ph0_q;
   logic [cotr_pkg::DATA_W-1:0] slotAIn1Ph90_q;
   logic [cotr_pkg::DATA_W-1:0] slotAIn2Ph90_q;
   logic [cotr_pkg::DATA_W-1:0] slotBIn1Ph0_q;
   logic [cotr_pkg::DATA_W-1:0] slotAIn2Ph0_d;
   logic [cotr_pkg::DATA_W-1:0] slotAIn1Ph90_d;
   logic [cotr_pkg::DATA_W-1:0] slotAIn2Ph90_d;
   logic [cotr_pkg::DATA_W-1:0] slotBIn1Ph0_d;

   // fuse load beats a same-cycle write so factory state is never half applied
   // fuse load or software overwrite
   assign slotAIn2Ph0_d  = nextWord(fuseLoad, wrEnAIn2Ph0, fuseCoreASecondPh0, regWrData, slotAIn2Ph0_q);
   assign slotAIn1Ph90_d = nextWord(fuseLoad, wrEnAIn1Ph90, fuseCoreAFirstPh90, regWrData, slotAIn1Ph90_q);
   assign slotAIn2Ph90_d = nextWord(fuseLoad, wrEnAIn2Ph90, fuseCoreASecondPh90, regWrData, slotAIn2Ph90_q);
   assign slotBIn1Ph0_d  = nextWord(fuseLoad, wrEnBIn1Ph0, fuseCoreBFirstPh0, regWrData, slotBIn1Ph0_q);

   // slot of core A, second input, 0 degrees
   always_ff @(posedge core_clk or negedge rstInt_n) begin
      if (!rstInt_n) begin
         slotAIn2Ph0_q <= cotr_pkg::REG_RESET;
      end else begin
         slotAIn2Ph0_q <= slotAIn2Ph0_d;
      end
   end

   // slot of core A, first input, 90 degrees
   always_ff @(posedge core_clk or negedge rstInt_n) begin
      if (!rstInt_n) begin
         slotAIn1Ph90_q <= cotr_pkg::REG_RESET;
      end else begin
         slotAIn1Ph90_q <= slotAIn1Ph90_d;
      end
   end

   // slot of core A, second input, 90 degrees
   always_ff @(posedge core_clk or negedge rstInt_n) begin
      if (!rstInt_n) begin
         slotAIn2Ph90_q <= cotr_pkg::REG_RESET;
      end else begin
         slotAIn2Ph90_q <= slotAIn2Ph90_d;
      end
   end

   // slot of core B, first input, 0 degrees
   always_ff @(posedge core_clk or negedge rstInt_n) begin
      if (!rstInt_n) begin
         slotBIn1Ph0_q <= cotr_pkg::REG_RESET;
      end else begin
         slotBIn1Ph0_q <= slotBIn1Ph0_d;
      end
   end

   // read answer in the cycle after the strobe only
   logic                        rdSelAIn2Ph0;
   logic                        rdSelAIn1Ph90;
   logic                        rdSelAIn2Ph90;
   logic                        rdSelBIn1Ph0;
   logic [cotr_pkg::DATA_W-1:0] rdWord;
   logic [cotr_pkg::DATA_W-1:0] rdData_d;
   logic [cotr_pkg::DATA_W-1:0] rdData_q;

   // one-hot read select; an idle or unmapped cycle leaves every select low
   assign rdSelAIn2Ph0  = rdHit & (addrIdx == cotr_pkg::IDX_A_IN2_PH0);
   assign rdSelAIn1Ph90 = rdHit & (addrIdx == cotr_pkg::IDX_A_IN1_PH90);
   assign rdSelAIn2Ph90 = rdHit & (addrIdx == cotr_pkg::IDX_A_IN2_PH90);
   assign rdSelBIn1Ph0  = rdHit & (addrIdx == cotr_pkg::IDX_B_IN1_PH0);

   assign rdWord   = ({cotr_pkg::DATA_W{rdSelAIn2Ph0}}  & slotAIn2Ph0_q)  |
                     ({cotr_pkg::DATA_W{rdSelAIn1Ph90}} & slotAIn1Ph90_q) |
                     ({cotr_pkg::DATA_W{rdSelAIn2Ph90}} & slotAIn2Ph90_q) |
                     ({cotr_pkg::DATA_W{rdSelBIn1Ph0}}  & slotBIn1Ph0_q);
   assign rdData_d = rdHit ? rdWord : cotr_pkg::RD_UNMAPPED;

   always_ff @(posedge core_clk or negedge rstInt_n) begin
      if (!rstInt_n) begin
         rdData_q <= cotr_pkg::RD_UNMAPPED;
      end else begin
         rdData_q <= rdData_d;
      end
   end
   assign regRdData = rdData_q;

   // trim field of each slot
   logic [cotr_pkg::TRIM_W-1:0] fieldAIn2Ph0;
   logic [cotr_pkg::TRIM_W-1:0] fieldAIn1Ph90;
   logic [cotr_pkg::TRIM_W-1:0] fieldAIn2Ph90;
   logic [cotr_pkg::TRIM_W-1:0] fieldBIn1Ph0;

   assign fieldAIn2Ph0  = trimField(slotAIn2Ph0_q);
   assign fieldAIn1Ph90 = trimField(slotAIn1Ph90_q);
   assign fieldAIn2Ph90 = trimField(slotAIn2Ph90_q);
   assign fieldBIn1Ph0  = trimField(slotBIn1Ph0_q);

   // core A selection; first input at 0 degrees lives in a neighbouring bank
   logic                        selAIn2Ph0;
   logic                        selAIn1Ph90;
   logic                        selAIn2Ph90;
   logic                        selBIn1Ph0;
   logic [cotr_pkg::TRIM_W-1:0] coreATrim_d;
   logic                        coreAValid_d;
   logic [cotr_pkg::TRIM_W-1:0] coreBTrim_d;
   logic                        coreBValid_d;

   assign selAIn2Ph0  = modeHit(fgCalEn, coreASecondInput, coreAPhase90, 1'b1, 1'b0);
   assign selAIn1Ph90 = modeHit(fgCalEn, coreASecondInput, coreAPhase90, 1'b0, 1'b1);
   assign selAIn2Ph90 = modeHit(fgCalEn, coreASecondInput, coreAPhase90, 1'b1, 1'b1);
   // core B first input, 0 degrees
   assign selBIn1Ph0  = modeHit(fgCalEn, coreBSecondInput, coreBPhase90, 1'b0, 1'b0);

   assign coreATrim_d  = selAIn2Ph0  ? fieldAIn2Ph0  :
                         selAIn1Ph90 ? fieldAIn1Ph90 :
                         selAIn2Ph90 ? fieldAIn2Ph90 : cotr_pkg::TRIM_RESET;
   assign coreAValid_d = selAIn2Ph0 | selAIn1Ph90 | selAIn2Ph90;
   assign coreBTrim_d  = selBIn1Ph0 ? fieldBIn1Ph0 : cotr_pkg::TRIM_RESET;
   assign coreBValid_d = selBIn1Ph0;

   // registered towards the cores to keep the analog trim path glitch free
   always_ff @(posedge core_clk or negedge rstInt_n) begin
      if (!rstInt_n) begin
         coreATrim <= cotr_pkg::TRIM_RESET;
      end else begin
         coreATrim <= coreATrim_d;
      end
   end

   // core A valid moves on the same edge as its trim, so the pair never splits
   always_ff @(posedge core_clk or negedge rstInt_n) begin
      if (!rstInt_n) begin
         coreATrimValid <= 1'b0;
      end else begin
         coreATrimValid <= coreAValid_d;
      end
   end

   // core B trim, registered like core A
   always_ff @(posedge core_clk or negedge rstInt_n) begin
      if (!rstInt_n) begin
         coreBTrim <= cotr_pkg::TRIM_RESET;
      end else begin
         coreBTrim <= coreBTrim_d;
      end
   end

   // core B valid, paired with its trim
   always_ff @(posedge core_clk or negedge rstInt_n) begin
      if (!rstInt_n) begin
         coreBTrimValid <= 1'b0;
      end else begin
         coreBTrimValid <= coreBValid_d;
      end
   end

endmodule

/* hdl/cotr_pkg.sv */
// shared constants of the converter offset trim register bank
package cotr_pkg;

   // register bus geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 16;
   localparam int NUM_REGS = 4;

   // printed byte offsets of the four trim registers
   localparam logic [11:0] OFS_CORE_A_SECOND_INPUT_PHASE0_OFFSET  = 12'h346;
   localparam logic [11:0] OFS_CORE_A_FIRST_INPUT_PHASE90_OFFSET  = 12'h348;
   localparam logic [11:0] OFS_CORE_A_SECOND_INPUT_PHASE90_OFFSET = 12'h34A;
   localparam logic [11:0] OFS_CORE_B_FIRST_INPUT_PHASE0_OFFSET   = 12'h34C;

   // array slot of each register inside the bank
   localparam logic [1:0] IDX_A_IN2_PH0  = 2'h0;
   localparam logic [1:0] IDX_A_IN1_PH90 = 2'h1;
   localparam logic [1:0] IDX_A_IN2_PH90 = 2'h2;
   localparam logic [1:0] IDX_B_IN1_PH0  = 2'h3;

   // field layout: offset value low, reserved nibble high
   localparam int TRIM_LSB = 0;
   localparam int TRIM_MSB = 11;
   localparam int TRIM_W   = 12;
   localparam int RSVD_LSB = 12;
   localparam int RSVD_MSB = 15;

   // value held before the fuse load arrives
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [11:0] TRIM_RESET = 12'h000;
   // read answer for an unmapped address
   localparam logic [15:0] RD_UNMAPPED = 16'h0000;

endpackage
